// ---- design/stm_link_port.sv ----
/*
 * stm_link_port: link-side end of the command crossing. Takes one decoded
 * command on the link clock, hands it to the core by a toggle handshake
 * and returns the core's answer.
 * Assumes the core holds its answer stable from its ack toggle onward.
 */
`timescale 1ns/10ps

module stm_link_port (
  input  wire logic              link_clk,
  input  wire logic              link_srst,
  input  wire logic              req_valid,
  input  wire stm_pkg::stm_req_s req,
  output      logic              busy,
  output      logic              resp_valid,
  output      stm_pkg::stm_resp_s resp,
  output      logic              req_tgl,
  output      stm_pkg::stm_req_s req_hold,
  input  wire logic              ack_tgl,
  input  wire stm_pkg::stm_resp_s core_resp
);

  typedef struct packed {
    logic               ack_s1;
    logic               ack_s2;
    logic               ack_seen;
    logic               req_tgl;
    logic               busy;
    logic               resp_valid;
    stm_pkg::stm_req_s  req;
    stm_pkg::stm_resp_s resp;
  } stm_link_s;

  stm_link_s r_reg;
  stm_link_s r_next;

  ////////////////////////////////////////////////////////////////////////
  // next state: one command in flight, later ones refused while busy
  always_comb
  begin
    r_next            = r_reg;
    r_next.ack_s1     = ack_tgl;
    r_next.ack_s2     = r_reg.ack_s1;
    r_next.resp_valid = 1'b0;
    if (req_valid && !r_reg.busy)
    begin
      // payload frozen in the same cycle as the toggle; the core reads it only after its two-flop sync
      r_next.req     = req;
      r_next.req_tgl = ~r_reg.req_tgl;
      r_next.busy    = 1'b1;
    end
    if (r_reg.busy && (r_reg.ack_s2 != r_reg.ack_seen))
    begin
      r_next.ack_seen   = r_reg.ack_s2;
      r_next.resp       = core_resp;
      r_next.resp_valid = 1'b1;
      r_next.busy       = 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_srst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign busy       = r_reg.busy;
  assign resp_valid = r_reg.resp_valid;
  assign resp       = r_reg.resp;
  assign req_tgl    = r_reg.req_tgl;
  assign req_hold   = r_reg.req;

endmodule // stm_link_port

// ---- design/stm_pkg.sv ----
/*
 * stm_pkg: shared constants, types and the limit quantiser for the
 * startup-timeout fault monitor.
 * Assumes a 25 MHz core clock and a link clock unrelated in phase.
 */
package stm_pkg;

  // command codes of the two registers
  localparam logic [7:0] CODE_LIMIT  = 8'h62;
  localparam logic [7:0] CODE_ACTION = 8'h63;

  // timing: millisecond tick from the core clock
  localparam int CLK_PERIOD_NS   = 40;
  localparam int MS_NS           = 1000000;
  localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W          = 16;
  localparam int MS_W            = 13;
  localparam int GRACE_S         = 4;
  localparam logic [MS_W-1:0] GRACE_MS = MS_W'(GRACE_S * 1000);
  localparam int RETRY_RISE_MULT = 7;

  // limit word layout
  localparam int LIMIT_MANT_W = 7;
  localparam logic [6:0] LIMIT_RST = 7'h00;
  localparam logic [8:0] LIMIT_FIXED_ZERO = 9'h000;

  // action byte layout
  localparam int ACT_STOP_BIT = 7;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_WAIT_W   = 6;
  localparam logic [2:0] RETRY_NONE   = 3'h0;
  localparam logic [2:0] RETRY_ALWAYS = 3'h7;
  localparam logic ACT_STOP_RST  = 1'b1;
  localparam logic ACT_RETRY_RST = 1'b1;

  // quantiser buckets above the direct range
  localparam logic [6:0] Q_DIRECT_MAX = 7'h06;
  localparam logic [6:0] Q_OVER_VALUE = 7'h64;
  localparam logic [6:0] Q_BOUND [8] = '{7'h09, 7'h0C, 7'h11, 7'h16, 7'h20, 7'h2C, 7'h3E, 7'h56};
  localparam logic [6:0] Q_VALUE [8] = '{7'h07, 7'h0A, 7'h0E, 7'h13, 7'h1B, 7'h25, 7'h34, 7'h48};

  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b000,
    SEQ_RAMP    = 3'b001,
    SEQ_RUN     = 3'b010,
    SEQ_WAIT    = 3'b011,
    SEQ_LATCHED = 3'b100
  } stm_seq_e;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } stm_req_s;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } stm_resp_s;

  typedef struct packed {
    logic other_summary;
    logic vout_summary;
    logic timeout_flag;
    logic comm_summary;
    logic invalid_data;
    logic invalid_cmd;
  } stm_status_s;

  // effective limit in ms; zero means no limit
  function automatic logic [6:0] quant_limit(input logic [6:0] mant);
    logic [6:0] res;
    res = Q_OVER_VALUE;
    for (int i = 7; i >= 0; i--)
    begin
      if (mant <= Q_BOUND[i])
        res = Q_VALUE[i];
    end
    if (mant <= Q_DIRECT_MAX)
      res = mant;
    return res;
  endfunction

endpackage

// ---- design/stm_startup_monitor.sv ----
/*
 * stm_startup_monitor: watches the soft-start ramp of the output, raises the
 * startup-timeout fault, keeps the two command registers and answers
 * commands that arrive from the link domain.
 * Assumes the sequencer pulses RAMP_START on entering soft start, holds
 * OUTPUT_ON while enabled and gives the effective rise time in ms.
 */
// Notes on behaviour
// [R1] the limit register bounds, in ms, how long the output may try to rise
// [R2] timer starts when soft start begins ramping the output
// [R3] as loop slave both commands are NACKed, flag invalid command, alert
// [R4] limit zero disables the timer entirely
// [R5] limit below rise time: fault 4 s after rise still short of threshold
// [R6] limit word: exponent and top four mantissa bits zero, low seven writable
// [R7] limit has no stored copy; restore-all returns it to zero
// [R8] programmed mantissa maps to one of sixteen effective limits
// [R9] fault sets status summary, vout summary, timeout flag and alert
// [R10] response register saved to the stored copy on store-all
// [R11] default response: shut down, restart after seven rise times
// [R12] response byte: stop select bit 7, zero bit 6, retry, retry wait
// [R13] stop select zero: keep running, still set flags, alert unless masked
// [R14] stop select one: shut down, then restart or stay off per retry
// [R15] retry 000 stays off until cleared; 111 retries without limit
// [R16] other retry values rejected with comm summary, invalid data, alert
// [R17] retry wait 111 waits seven rise times before each retry
// [R18] retry wait bits mirror bit 5; only that bit is stored
// [R19] ms tick drives the timer; cleared on threshold or output off
`timescale 1ns/10ps

module stm_startup_monitor #(
  parameter int         TICK_CYCLES      = stm_pkg::TICK_CYCLES_DEF,
  parameter logic [7:0] CMD_CLEAR_FAULTS = 8'h03,
  parameter logic [7:0] CMD_STORE_ALL    = 8'h11,
  parameter logic [7:0] CMD_RESTORE_ALL  = 8'h12
) (
  input  wire logic               CLK,
  input  wire logic               SRST,
  input  wire logic               LINK_CLK,
  input  wire logic               LINK_SRST,
  input  wire logic               LINK_REQ_VALID,
  input  wire stm_pkg::stm_req_s  LINK_REQ,
  output      logic               LINK_BUSY,
  output      logic               LINK_RESP_VALID,
  output      stm_pkg::stm_resp_s LINK_RESP,
  input  wire logic               LOOP_SLAVE_PIN,
  input  wire logic               ALERT_MASK_PIN,
  input  wire logic               VOUT_ABOVE_UVF,
  input  wire logic               OUTPUT_ON,
  input  wire logic               RAMP_START,
  input  wire logic [6:0]         RISE_MS,
  output      logic               OUTPUT_SHUTDOWN,
  output      logic               RESTART_REQ,
  output      logic               TIMEOUT_FAULT,
  output      stm_pkg::stm_status_s STATUS,
  output      logic               SMBALERT_N
);

  localparam logic [stm_pkg::TICK_W-1:0] TICK_LAST = stm_pkg::TICK_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic                     rq_s1;
    logic                     rq_s2;
    logic                     rq_seen;
    logic                     ack_tgl;
    stm_pkg::stm_resp_s       resp;
    logic [6:0]               limit_mant;
    logic                     act_stop;
    logic                     act_retry;
    logic                     nv_stop;
    logic                     nv_retry;
    stm_pkg::stm_status_s     status;
    logic                     alert_n;
    logic                     uv_s1;
    logic                     uv_s2;
    logic                     loop_s1;
    logic                     loop_s2;
    logic                     mask_s1;
    logic                     mask_s2;
    stm_pkg::stm_seq_e        seq;
    logic [stm_pkg::TICK_W-1:0] tick_cnt;
    logic [stm_pkg::MS_W-1:0] ms_cnt;
    logic                     shutdown;
    logic                     restart;
    logic                     fault_pulse;
  } stm_core_s;

  localparam stm_core_s CORE_RST = '{
    act_stop:  stm_pkg::ACT_STOP_RST,
    act_retry: stm_pkg::ACT_RETRY_RST,
    nv_stop:   stm_pkg::ACT_STOP_RST,
    nv_retry:  stm_pkg::ACT_RETRY_RST,
    limit_mant: stm_pkg::LIMIT_RST,
    alert_n:   1'b1,
    seq:       stm_pkg::SEQ_IDLE,
    default:   '0
  };

  stm_core_s r_reg;
  stm_core_s r_next;

  logic                     req_tgl;
  stm_pkg::stm_req_s        req_hold;
  logic                     new_cmd;
  logic                     clr_faults;
  logic                     ev_timeout;
  logic                     ev_inv_cmd;
  logic                     ev_inv_data;
  logic                     ms_tick;
  logic                     timer_on;
  logic [6:0]               eff_limit;
  logic [stm_pkg::MS_W-1:0] deadline_ms;
  logic [stm_pkg::MS_W-1:0] wait_ms;
  logic [stm_pkg::MS_W-1:0] ms_inc;
  logic [2:0]               wr_retry;

  ////////////////////////////////////////////////////////////////////////
  // link side of the crossing lives on the link clock
  stm_link_port u_link (
    .link_clk   (LINK_CLK),
    .link_srst  (LINK_SRST),
    .req_valid  (LINK_REQ_VALID),
    .req        (LINK_REQ),
    .busy       (LINK_BUSY),
    .resp_valid (LINK_RESP_VALID),
    .resp       (LINK_RESP),
    .req_tgl    (req_tgl),
    .req_hold   (req_hold),
    .ack_tgl    (r_reg.ack_tgl),
    .core_resp  (r_reg.resp)
  );

  ////////////////////////////////////////////////////////////////////////
  // derived timing values
  // [R8] quantise the mantissa
  assign eff_limit = stm_pkg::quant_limit(r_reg.limit_mant);
  // [R4] zero disables timer
  assign timer_on  = (eff_limit != 7'h00);
  // [R5] short limit grace
  assign deadline_ms = (eff_limit < RISE_MS) ?
                       ({6'h00, RISE_MS} + stm_pkg::GRACE_MS) : {6'h00, eff_limit};
  // [R17] seven rise times
  assign wait_ms  = stm_pkg::MS_W'(stm_pkg::RETRY_RISE_MULT * RISE_MS);
  // [R19] millisecond tick
  assign ms_tick  = (r_reg.tick_cnt == TICK_LAST);
  assign ms_inc   = r_reg.ms_cnt + 1'b1;
  assign new_cmd  = (r_reg.rq_s2 != r_reg.rq_seen);
  assign wr_retry = req_hold.wdata[stm_pkg::ACT_RETRY_HI:stm_pkg::ACT_RETRY_LO];

  ////////////////////////////////////////////////////////////////////////
  // next state of the whole core
  always_comb
  begin
    r_next             = r_reg;
    clr_faults         = 1'b0;
    ev_timeout         = 1'b0;
    ev_inv_cmd         = 1'b0;
    ev_inv_data        = 1'b0;
    // pins pass two flops; only the second is read by logic
    r_next.rq_s1       = req_tgl;
    r_next.rq_s2       = r_reg.rq_s1;
    r_next.uv_s1       = VOUT_ABOVE_UVF;
    r_next.uv_s2       = r_reg.uv_s1;
    r_next.loop_s1     = LOOP_SLAVE_PIN;
    r_next.loop_s2     = r_reg.loop_s1;
    r_next.mask_s1     = ALERT_MASK_PIN;
    r_next.mask_s2     = r_reg.mask_s1;
    r_next.restart     = 1'b0;
    r_next.fault_pulse = 1'b0;

    // command handling; answer is held until the next command arrives
    if (new_cmd)
    begin
      r_next.rq_seen    = r_reg.rq_s2;
      r_next.ack_tgl    = ~r_reg.ack_tgl;
      r_next.resp.ack   = 1'b1;
      r_next.resp.rdata = 16'h0000;
      if ((req_hold.code == stm_pkg::CODE_LIMIT || req_hold.code == stm_pkg::CODE_ACTION)
          && r_reg.loop_s2)
      begin
        // [R3] loop slave lockout
        r_next.resp.ack = 1'b0;
        ev_inv_cmd      = 1'b1;
      end
      else if (req_hold.code == stm_pkg::CODE_LIMIT)
      begin
        // [R6] only low seven writable
        if (req_hold.write)
          r_next.limit_mant = req_hold.wdata[stm_pkg::LIMIT_MANT_W-1:0];
        else
          r_next.resp.rdata = {stm_pkg::LIMIT_FIXED_ZERO, r_reg.limit_mant};
      end
      else if (req_hold.code == stm_pkg::CODE_ACTION)
      begin
        if (!req_hold.write)
          // [R18] wait bits mirror retry
          r_next.resp.rdata = {8'h00, r_reg.act_stop, 1'b0,
                               {stm_pkg::ACT_WAIT_W{r_reg.act_retry}}};
        // [R16] reject mixed retry
        else if (wr_retry != stm_pkg::RETRY_NONE && wr_retry != stm_pkg::RETRY_ALWAYS)
        begin
          r_next.resp.ack = 1'b0;
          ev_inv_data     = 1'b1;
        end
        else
        begin
          // [R12] keep stop and retry
          r_next.act_stop  = req_hold.wdata[stm_pkg::ACT_STOP_BIT];
          r_next.act_retry = req_hold.wdata[stm_pkg::ACT_RETRY_HI];
        end
      end
      else if (req_hold.code == CMD_STORE_ALL && req_hold.write)
      begin
        // [R10] save response bits
        r_next.nv_stop  = r_reg.act_stop;
        r_next.nv_retry = r_reg.act_retry;
      end
      else if (req_hold.code == CMD_RESTORE_ALL && req_hold.write)
      begin
        // [R7] limit back to zero
        r_next.limit_mant = stm_pkg::LIMIT_RST;
        r_next.act_stop   = r_reg.nv_stop;
        r_next.act_retry  = r_reg.nv_retry;
      end
      else if (req_hold.code == CMD_CLEAR_FAULTS && req_hold.write)
        clr_faults = 1'b1;
      else
        // codes of other blocks are not served here
        r_next.resp.ack = 1'b0;
    end

    // ramp supervision
    unique case (r_reg.seq)
      stm_pkg::SEQ_IDLE,
      stm_pkg::SEQ_RUN:
      begin
        // [R2] start at soft start
        if (RAMP_START && OUTPUT_ON)
        begin
          r_next.seq      = stm_pkg::SEQ_RAMP;
          r_next.tick_cnt = '0;
          r_next.ms_cnt   = '0;
        end
        else if (!OUTPUT_ON)
          r_next.seq = stm_pkg::SEQ_IDLE;
      end
      stm_pkg::SEQ_RAMP:
      begin
        r_next.tick_cnt = ms_tick ? '0 : r_reg.tick_cnt + 1'b1;
        // [R19] clear on threshold or off
        if (!OUTPUT_ON)
          r_next.seq = stm_pkg::SEQ_IDLE;
        else if (r_reg.uv_s2)
          r_next.seq = stm_pkg::SEQ_RUN;
        else if (ms_tick)
        begin
          r_next.ms_cnt = ms_inc;
          // [R1] deadline reached
          if (timer_on && ms_inc >= deadline_ms)
          begin
            ev_timeout         = 1'b1;
            r_next.fault_pulse = 1'b1;
            r_next.tick_cnt    = '0;
            r_next.ms_cnt      = '0;
            // [R13] ignore keeps running
            if (!r_reg.act_stop)
              r_next.seq = stm_pkg::SEQ_RUN;
            // [R14] stop then retry
            else if (r_reg.act_retry)
              r_next.seq = stm_pkg::SEQ_WAIT;
            // [R15] retry none latches
            else
              r_next.seq = stm_pkg::SEQ_LATCHED;
          end
        end
      end
      stm_pkg::SEQ_WAIT:
      begin
        r_next.tick_cnt = ms_tick ? '0 : r_reg.tick_cnt + 1'b1;
        // commanded off ends the endless retry loop
        if (!OUTPUT_ON)
          r_next.seq = stm_pkg::SEQ_IDLE;
        else if (ms_tick)
        begin
          r_next.ms_cnt = ms_inc;
          // [R11] restart after wait
          if (ms_inc >= wait_ms)
          begin
            r_next.restart = 1'b1;
            r_next.seq     = stm_pkg::SEQ_IDLE;
          end
        end
      end
      stm_pkg::SEQ_LATCHED:
      begin
        // [R15] off until cleared
        if (clr_faults)
          r_next.seq = stm_pkg::SEQ_IDLE;
      end
      default:
        r_next.seq = stm_pkg::SEQ_IDLE;
    endcase

    // sticky flags: a set in the clearing cycle survives
    if (clr_faults)
      r_next.status = '0;
    // [R9] fault status bits
    if (ev_timeout)
    begin
      r_next.status.other_summary = 1'b1;
      r_next.status.vout_summary  = 1'b1;
      r_next.status.timeout_flag  = 1'b1;
    end
    // [R3] invalid command flag
    if (ev_inv_cmd)
    begin
      r_next.status.invalid_cmd   = 1'b1;
      r_next.status.other_summary = 1'b1;
    end
    // [R16] comm flags
    if (ev_inv_data)
    begin
      r_next.status.comm_summary = 1'b1;
      r_next.status.invalid_data = 1'b1;
    end

    // [R13] mask gates the timeout alert
    r_next.alert_n = ~((r_next.status.timeout_flag & ~r_reg.mask_s2)
                       | r_next.status.invalid_cmd | r_next.status.comm_summary);
    // [R14] output held off
    r_next.shutdown = (r_next.seq == stm_pkg::SEQ_WAIT) ||
                      (r_next.seq == stm_pkg::SEQ_LATCHED);
  end

  ////////////////////////////////////////////////////////////////////////
  // the single state register
  always_ff @(posedge CLK)
  begin
    if (SRST)
      r_reg <= CORE_RST;
    else
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign OUTPUT_SHUTDOWN = r_reg.shutdown;
  assign RESTART_REQ     = r_reg.restart;
  assign TIMEOUT_FAULT   = r_reg.fault_pulse;
  assign STATUS          = r_reg.status;
  assign SMBALERT_N      = r_reg.alert_n;

endmodule // stm_startup_monitor

// ---- sim/stm_host_model.sv ----
/*
 * stm_host_model: host on the command link; one command at a time.
 * Assumes the monitor's valid/busy/answer handshake on the link clock.
 */
`timescale 1ns/10ps

module stm_host_model (
  input  wire logic               link_clk,
  input  wire logic               link_busy,
  input  wire logic               link_resp_valid,
  input  wire stm_pkg::stm_resp_s link_resp,
  output      logic               link_req_valid,
  output      stm_pkg::stm_req_s  link_req
);
  initial
  begin
    link_req_valid = 1'b0;
    link_req       = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle cycles first let the host be slow; ok low means no answer came
  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data,
                      input int idle, output stm_pkg::stm_resp_s r, output logic ok);
    ok = 1'b0;
    r  = '0;
    repeat (idle + 1) @(negedge link_clk);
    for (int i = 0; i < 20 && link_busy !== 1'b0; i++)
      @(negedge link_clk);
    link_req_valid = 1'b1;
    link_req       = '{write: w, code: code, wdata: data};
    @(negedge link_clk);
    link_req_valid = 1'b0;
    // a released request must not keep showing the last word
    link_req       = ~link_req;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      @(negedge link_clk);
      if (link_resp_valid === 1'b1)
      begin
        r  = link_resp;
        ok = 1'b1;
      end
    end
  endtask
endmodule // stm_host_model

// ---- sim/stm_startup_properties.sv ----
/*
 * stm_startup_properties: concurrent checks on the monitor's ports.
 * Assumes a bind from the bench top; each domain has its own reset.
 */
`timescale 1ns/10ps

module stm_startup_properties #(
  parameter int TICK_CYCLES = stm_pkg::TICK_CYCLES_DEF
) (
  input wire logic                 CLK,
  input wire logic                 SRST,
  input wire logic                 LINK_CLK,
  input wire logic                 LINK_SRST,
  input wire logic                 LINK_REQ_VALID,
  input wire logic                 LINK_BUSY,
  input wire logic                 LINK_RESP_VALID,
  input wire logic                 ALERT_MASK_PIN,
  input wire logic                 OUTPUT_ON,
  input wire logic                 OUTPUT_SHUTDOWN,
  input wire logic                 RESTART_REQ,
  input wire logic                 TIMEOUT_FAULT,
  input wire stm_pkg::stm_status_s STATUS,
  input wire logic                 SMBALERT_N
);
  // shortest legal hold: seven rise times of at least 1 ms, less sync slack
  localparam int RETRY_MIN = 7 * TICK_CYCLES - 2;
  int hold_cnt;

  // hold-off length in core cycles
  always_ff @(posedge CLK)
    hold_cnt <= (SRST || !OUTPUT_SHUTDOWN) ? 0 : hold_cnt + 1;

  ////////////////////////////////////////////////////////////////////////////
  // link command: taken, busy for a while, then answered
  sequence s_take;
    LINK_REQ_VALID && !LINK_BUSY;
  endsequence
  sequence s_answer;
    LINK_BUSY [*3] ##[1:5] (LINK_RESP_VALID && !LINK_BUSY);
  endsequence

  chk_link_answer: assert property (@(posedge LINK_CLK) disable iff (LINK_SRST)
    s_take |=> s_answer) else $error("link command not answered in time");
  chk_resp_single: assert property (@(posedge LINK_CLK) disable iff (LINK_SRST)
    LINK_RESP_VALID |=> !LINK_RESP_VALID) else $error("answer pulse too long");
  chk_reset_clean: assert property (@(posedge CLK) disable iff (SRST)
    $fell(SRST) |-> STATUS == '0 && SMBALERT_N && !OUTPUT_SHUTDOWN)
    else $error("outputs not idle after reset");
  chk_fault_flags: assert property (@(posedge CLK) disable iff (SRST)
    TIMEOUT_FAULT |-> STATUS.timeout_flag && STATUS.vout_summary && STATUS.other_summary)
    else $error("fault without its status bits");
  chk_fault_alert: assert property (@(posedge CLK) disable iff (SRST)
    TIMEOUT_FAULT && !ALERT_MASK_PIN && !$past(ALERT_MASK_PIN, 3) |-> !SMBALERT_N)
    else $error("unmasked fault without alert");
  chk_alert_cause: assert property (@(posedge CLK) disable iff (SRST)
    !SMBALERT_N |-> STATUS.timeout_flag || STATUS.invalid_cmd || STATUS.comm_summary)
    else $error("alert without a cause");
  chk_fault_output: assert property (@(posedge CLK) disable iff (SRST)
    TIMEOUT_FAULT |-> $past(OUTPUT_ON)) else $error("fault while output off");
  chk_shutdown_cause: assert property (@(posedge CLK) disable iff (SRST)
    $rose(OUTPUT_SHUTDOWN) |-> TIMEOUT_FAULT) else $error("shutdown without fault");
  chk_retry_wait: assert property (@(posedge CLK) disable iff (SRST)
    RESTART_REQ |-> hold_cnt >= RETRY_MIN) else $error("retry wait too short");
endmodule // stm_startup_properties

// ---- sim/tb.sv ----
/*
 * tb: self-checking bench for the startup-timeout monitor.
 * Assumes a 4-cycle ms tick and the host model on the command link.
 */
`timescale 1ns/10ps

module tb;
  localparam int TICK = 4;
  logic                 clk, srst, lclk, lsrst, req_valid, busy, resp_valid;
  logic                 slave, mask, vout_ok, out_on, ramp_start;
  logic                 shutdown, restart, fault, alert_n;
  logic [6:0]           rise;
  stm_pkg::stm_req_s    req;
  stm_pkg::stm_resp_s   resp, rsp;
  stm_pkg::stm_status_s status;
  int                   bad_count = 0;
  int                   n_compared = 0;
  int                   seed = 32'h752D;
  int                   cyc, m;
  int                   corner [8] = '{1, 6, 7, 9, 10, 86, 87, 127};

  ////////////////////////////////////////////////////////////////////////////
  // link clock slower and offset, so the two never line up
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #80 lclk = ~lclk;
  end

  stm_startup_monitor #(.TICK_CYCLES(TICK)) uut (.CLK(clk), .SRST(srst), .LINK_CLK(lclk),
    .LINK_SRST(lsrst), .LINK_REQ_VALID(req_valid), .LINK_REQ(req), .LINK_BUSY(busy),
    .LINK_RESP_VALID(resp_valid), .LINK_RESP(resp), .LOOP_SLAVE_PIN(slave),
    .ALERT_MASK_PIN(mask), .VOUT_ABOVE_UVF(vout_ok), .OUTPUT_ON(out_on),
    .RAMP_START(ramp_start), .RISE_MS(rise), .OUTPUT_SHUTDOWN(shutdown),
    .RESTART_REQ(restart), .TIMEOUT_FAULT(fault), .STATUS(status), .SMBALERT_N(alert_n));
  stm_host_model host (.link_clk(lclk), .link_busy(busy), .link_resp_valid(resp_valid),
    .link_resp(resp), .link_req_valid(req_valid), .link_req(req));

  task automatic close_out();
    $display("compared %0d, bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a lost answer counts as a mismatch and ends the run
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
    logic ok;
    host.xfer(w, c, d, $random(seed) & 3, rsp, ok);
    if (!ok)
    begin
      bad_count++;
      close_out();
    end
  endtask

  // effective limit in ms for a programmed mantissa
  function automatic int q_ms(input int v);
    int b [8] = '{9, 12, 17, 22, 32, 44, 62, 86};
    int e [8] = '{7, 10, 14, 19, 27, 37, 52, 72};
    if (v <= 6)
      return v;
    for (int i = 0; i < 8; i++)
      if (v <= b[i])
        return e[i];
    return 100;
  endfunction

  // start a soft start; cyc is cycles to the fault or -1
  task automatic ramp(input logic [6:0] r, input int uv_at, input int bound);
    @(negedge clk);
    cyc = -1;
    rise = r;
    out_on = 1'b0;
    @(negedge clk);
    out_on = 1'b1;
    ramp_start = 1'b1;
    @(negedge clk);
    ramp_start = 1'b0;
    for (int i = 1; i <= bound && cyc < 0; i++)
    begin
      @(negedge clk);
      vout_ok = (i == uv_at) ? 1'b1 : vout_ok;
      cyc = (fault === 1'b1) ? i : -1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {srst, lsrst} = 2'h3;
    {slave, mask, vout_ok, out_on, ramp_start} = 5'h00;
    rise = 7'h01;
    repeat (20) @(negedge clk);
    {srst, lsrst} = 2'h0;
    repeat (20) @(negedge clk);
    op(1'b0, 8'h62, 16'h0000);
    check({rsp.ack, rsp.rdata}, {1'b1, 16'h0000}, "limit reset");
    op(1'b0, 8'h63, 16'h0000);
    check({rsp.ack, rsp.rdata}, {1'b1, 16'h00BF}, "action reset");
    op(1'b1, 8'h62, 16'hFFFF);
    op(1'b0, 8'h62, 16'h0000);
    check(rsp.rdata, 16'h007F, "limit fixed bits");
    op(1'b1, 8'h63, 16'h0008);
    check({rsp.ack, status.comm_summary, status.invalid_data, alert_n}, 4'h6, "bad retry");
    op(1'b0, 8'h63, 16'h0000);
    check(rsp.rdata, 16'h00BF, "action kept");
    op(1'b1, 8'h03, 16'h0000);
    check({status, alert_n}, 7'h01, "cleared");
    op(1'b1, 8'h63, 16'h0038);
    op(1'b0, 8'h63, 16'h0000);
    check(rsp.rdata, 16'h003F, "wait mirror");
    // corners of the limit table, then random mantissas, in ignore mode
    for (int i = 0; i < 11; i++)
    begin
      m = (i < 8) ? corner[i] : (($random(seed) & 32'h7F) | 1);
      mask = i[0];
      op(1'b1, 8'h62, 16'(m));
      ramp(7'h01, 0, 500);
      check(cyc, q_ms(m) * TICK, "limit time");
      check({status.other_summary, status.vout_summary, status.timeout_flag, shutdown},
            4'hE, "ignore flags");
      check(alert_n, mask, "alert mask");
    end
    op(1'b1, 8'h62, 16'h0000);
    ramp(7'h01, 0, 600);
    check(cyc, -1, "no limit");
    op(1'b1, 8'h62, 16'h000A);
    ramp(7'h01, 20, 100);
    check(cyc, -1, "threshold reached");
    vout_ok = 1'b0;
    op(1'b1, 8'h62, 16'h0001);
    ramp(7'h02, 0, 16100);
    check(cyc, 4002 * TICK, "grace time");
    op(1'b1, 8'h03, 16'h0000);
    op(1'b1, 8'h63, 16'h00BF);
    op(1'b1, 8'h62, 16'h0002);
    ramp(7'h01, 0, 20);
    check(shutdown, 1'b1, "shut down");
    for (cyc = 0; cyc < 60 && restart !== 1'b1; cyc++)
      @(negedge clk);
    check(32'(cyc inside {[7 * TICK - 2:7 * TICK + 2]}), 1, "retry wait");
    op(1'b1, 8'h63, 16'h0080);
    op(1'b0, 8'h63, 16'h0000);
    check(rsp.rdata, 16'h0080, "no retry read");
    ramp(7'h01, 0, 20);
    ramp(7'h01, 0, 100);
    check({cyc[0], shutdown}, 2'h3, "latched off");
    op(1'b1, 8'h03, 16'h0000);
    check(shutdown, 1'b0, "latch cleared");
    op(1'b1, 8'h11, 16'h0000);
    op(1'b1, 8'h63, 16'h00BF);
    op(1'b1, 8'h62, 16'h0005);
    op(1'b1, 8'h12, 16'h0000);
    op(1'b0, 8'h62, 16'h0000);
    check(rsp.rdata, 16'h0000, "restored limit");
    op(1'b0, 8'h63, 16'h0000);
    check(rsp.rdata, 16'h0080, "restored action");
    @(negedge clk);
    slave = 1'b1;
    op(1'b1, 8'h62, 16'h0009);
    check(rsp.ack, 1'b0, "slave write");
    op(1'b0, 8'h63, 16'h0000);
    check({rsp.ack, status.invalid_cmd, alert_n}, 3'h2, "slave read");
    @(negedge clk);
    slave = 1'b0;
    op(1'b0, 8'h62, 16'h0000);
    check(rsp.rdata, 16'h0000, "slave write ignored");
    close_out();
  end
endmodule // tb

bind stm_startup_monitor stm_startup_properties #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLK(CLK), .SRST(SRST), .LINK_CLK(LINK_CLK), .LINK_SRST(LINK_SRST),
  .LINK_REQ_VALID(LINK_REQ_VALID), .LINK_BUSY(LINK_BUSY), .LINK_RESP_VALID(LINK_RESP_VALID),
  .ALERT_MASK_PIN(ALERT_MASK_PIN), .OUTPUT_ON(OUTPUT_ON), .OUTPUT_SHUTDOWN(OUTPUT_SHUTDOWN),
  .RESTART_REQ(RESTART_REQ), .TIMEOUT_FAULT(TIMEOUT_FAULT), .STATUS(STATUS),
  .SMBALERT_N(SMBALERT_N));
